// ==== hdl/cca_defines.svh ====
// address map, field positions, reset values and pc step of the condition/add alu
`ifndef CCA_DEFINES_SVH
`define CCA_DEFINES_SVH

`define CCA_ADDR_W          8
`define CCA_ADDR_DST        8'h00
`define CCA_ADDR_SRC        8'h04
`define CCA_ADDR_FLAGS      8'h08
`define CCA_ADDR_CTRL       8'h0C
`define CCA_ADDR_STATUS     8'h10
`define CCA_ADDR_PC         8'h14
`define CCA_ADDR_TARGET     8'h18

`define CCA_FLAG_C          0
`define CCA_FLAG_Z          1
`define CCA_FLAG_S          2
`define CCA_FLAG_V          3

`define CCA_CTRL_COND_LSB   0
`define CCA_CTRL_GO_ADD     8
`define CCA_CTRL_GO_ADC     9
`define CCA_CTRL_GO_JMP     10

`define CCA_STAT_PEND       0
`define CCA_STAT_TAKEN      1

`define CCA_RST_BYTE        8'h00
`define CCA_RST_FLAGS       4'h0
`define CCA_RST_COND        4'h0
`define CCA_RST_PC          16'h0000
`define CCA_PC_STEP         16'h0002
`define CCA_SIGN_BIT        7

`endif

// ==== hdl/cca_pkg.sv ====
// types shared by the condition/add alu files
package cca_pkg;

    typedef enum logic [2:0] {
        CCA_OP_IDLE = 3'b000,
        CCA_OP_ADD  = 3'b001,
        CCA_OP_ADC  = 3'b010,
        CCA_OP_JMP  = 3'b100
    } cca_op_t;

    typedef enum logic [3:0] {
        CCA_CS_NEVER        = 4'h0,
        CCA_CS_SIGNED_LT    = 4'h1,
        CCA_CS_SIGNED_LE    = 4'h2,
        CCA_CS_UNSIGNED_LE  = 4'h3,
        CCA_CS_OVF_SET      = 4'h4,
        CCA_CS_SIGN_SET     = 4'h5,
        CCA_CS_EQUAL        = 4'h6,
        CCA_CS_UNSIGNED_LT  = 4'h7,
        CCA_CS_ALWAYS       = 4'h8,
        CCA_CS_SIGNED_GE    = 4'h9,
        CCA_CS_SIGNED_GT    = 4'hA,
        CCA_CS_UNSIGNED_GT  = 4'hB,
        CCA_CS_OVF_CLEAR    = 4'hC,
        CCA_CS_SIGN_CLEAR   = 4'hD,
        CCA_CS_UNEQUAL      = 4'hE,
        CCA_CS_UNSIGNED_GE  = 4'hF
    } cca_cond_t;

endpackage

// ==== hdl/cca_cond_eval.sv ====
// decodes the 4-bit condition selector against the c, z, s, v flags
`timescale 1ns/10ps
`default_nettype none
`include "cca_defines.svh"

module cca_cond_eval (
    // selector and flags
    input  wire logic [3:0] cond_select,
    input  wire logic [3:0] flags,
    // decision
    output logic            cond_true
);
    import cca_pkg::*;

    logic flag_c;
    logic flag_z;
    logic flag_s;
    logic flag_v;
    logic s_xor_v;

    assign flag_c  = flags[`CCA_FLAG_C];
    assign flag_z  = flags[`CCA_FLAG_Z];
    assign flag_s  = flags[`CCA_FLAG_S];
    assign flag_v  = flags[`CCA_FLAG_V];
    assign s_xor_v = flag_s ^ flag_v;

    always_comb begin
        case (cca_cond_t'(cond_select))
            CCA_CS_NEVER:       cond_true = 1'b0;
            CCA_CS_ALWAYS:      cond_true = 1'b1;
            CCA_CS_UNSIGNED_LT: cond_true = flag_c;
            CCA_CS_UNSIGNED_GE: cond_true = ~flag_c;
            CCA_CS_EQUAL:       cond_true = flag_z;
            CCA_CS_UNEQUAL:     cond_true = ~flag_z;
            CCA_CS_SIGN_CLEAR:  cond_true = ~flag_s;
            CCA_CS_SIGN_SET:    cond_true = flag_s;
            CCA_CS_OVF_SET:     cond_true = flag_v;
            CCA_CS_OVF_CLEAR:   cond_true = ~flag_v;
            CCA_CS_SIGNED_GE:   cond_true = ~s_xor_v;
            CCA_CS_SIGNED_LT:   cond_true = s_xor_v;
            CCA_CS_SIGNED_GT:   cond_true = ~(flag_z | s_xor_v);
            CCA_CS_SIGNED_LE:   cond_true = flag_z | s_xor_v;
            CCA_CS_UNSIGNED_GT: cond_true = ~flag_c & ~flag_z;
            CCA_CS_UNSIGNED_LE: cond_true = flag_c | flag_z;
            default:            cond_true = 1'b0;
        endcase
    end

endmodule // cca_cond_eval

`default_nettype wire

// ==== hdl/cca_top.sv ====
// condition-code evaluation and add/add-with-carry datapath with apb registers
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "cca_defines.svh"

// Summary of operation
// - jumps carry a 4-bit condition selector
// - 0000 never jumps, 1000 always jumps
// - 0111 carry set, 1111 carry clear
// - 0110 zero set, 1110 zero clear
// - 1101/0101 sign clear/set; 1100/0100 overflow
// - signed compares from sign xor overflow, zero
// - 1011 c and z clear; 0011 either set
// - add-with-carry writes dst plus src plus carry
// - plain add ignores carry, writes sum
// - carry flag is carry out of bit 7
// - zero and sign flags follow the result
// - overflow when same-sign operands flip sign
module cca_top (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // apb slave
    input  wire logic [`CCA_ADDR_W-1:0] paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // decoder request
    input  wire logic                   ex_valid,
    input  wire cca_pkg::cca_op_t       ex_op,
    input  wire logic [3:0]             ex_cond,
    input  wire logic [7:0]             ex_dst,
    input  wire logic [7:0]             ex_src,
    // results to decoder and register file
    output logic                        res_valid,
    output logic      [7:0]             res_data,
    output logic      [3:0]             flags_out,
    output logic                        jump_valid,
    output logic                        jump_taken,
    output logic      [15:0]            pc_out
);
    import cca_pkg::*;

    // software-visible state
    logic [7:0]   dst_reg;
    logic [7:0]   src_reg;
    logic [3:0]   flags_reg;
    logic [3:0]   cond_reg;
    logic [15:0]  target_reg;
    logic         pend_valid;
    cca_op_t      pend_op;

    // apb strobes
    logic         wr_fire;
    logic         addr_ok;
    logic [31:0]  next_rdata;
    logic         wr_dst;
    logic         wr_src;
    logic         wr_flags;
    logic         wr_cond;
    logic         wr_go;
    logic         wr_target;
    logic         wr_pc;

    // operation in flight this cycle
    cca_op_t      cur_op;
    logic [7:0]   op_a;
    logic [7:0]   op_b;
    logic [3:0]   op_cond;
    logic         ex_ok;
    logic         carry_in;
    logic [8:0]   sum9;
    logic [7:0]   sum8;
    logic [3:0]   next_flags;
    logic         cond_true;
    logic         is_add;
    logic         is_jmp;

    // apb decode
    assign wr_fire = psel & penable & pready & pwrite;

    // per-register write strobes, qualified by byte lane except target and pc
    assign wr_dst    = wr_fire & (paddr == `CCA_ADDR_DST) & pstrb[0];
    assign wr_src    = wr_fire & (paddr == `CCA_ADDR_SRC) & pstrb[0];
    assign wr_flags  = wr_fire & (paddr == `CCA_ADDR_FLAGS) & pstrb[0];
    assign wr_cond   = wr_fire & (paddr == `CCA_ADDR_CTRL) & pstrb[0];
    assign wr_go     = wr_fire & (paddr == `CCA_ADDR_CTRL) & pstrb[1];
    assign wr_target = wr_fire & (paddr == `CCA_ADDR_TARGET);
    assign wr_pc     = wr_fire & (paddr == `CCA_ADDR_PC);

    always_comb begin
        addr_ok    = 1'b1;
        next_rdata = 32'h0000_0000;
        case (paddr)
            `CCA_ADDR_DST:    next_rdata[7:0]  = dst_reg;
            `CCA_ADDR_SRC:    next_rdata[7:0]  = src_reg;
            `CCA_ADDR_FLAGS:  next_rdata[3:0]  = flags_reg;
            `CCA_ADDR_CTRL:   next_rdata[3:0]  = cond_reg;
            `CCA_ADDR_STATUS: begin
                next_rdata[`CCA_STAT_PEND]  = pend_valid;
                next_rdata[`CCA_STAT_TAKEN] = jump_taken;
            end
            `CCA_ADDR_PC:     next_rdata[15:0] = pc_out;
            `CCA_ADDR_TARGET: next_rdata[15:0] = target_reg;
            default:          addr_ok          = 1'b0;
        endcase
    end

    // one wait-free access phase; data and error from flops
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~pready & ~addr_ok;
            if (psel & ~penable & ~pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    // operand selection: decoder request beats a pending software request
    assign ex_ok = ex_valid & ((ex_op == CCA_OP_ADD) | (ex_op == CCA_OP_ADC)
                             | (ex_op == CCA_OP_JMP));

    always_comb begin
        cur_op  = CCA_OP_IDLE;
        op_a    = dst_reg;
        op_b    = src_reg;
        op_cond = cond_reg;
        if (ex_ok) begin
            cur_op  = ex_op;
            op_a    = ex_dst;
            op_b    = ex_src;
            op_cond = ex_cond;
        end else if (pend_valid) begin
            cur_op  = pend_op;
        end
    end

    assign is_add = (cur_op == CCA_OP_ADD) | (cur_op == CCA_OP_ADC);
    assign is_jmp = (cur_op == CCA_OP_JMP);

    // adder and flags
    assign carry_in = (cur_op == CCA_OP_ADC) & flags_reg[`CCA_FLAG_C];
    assign sum9     = {1'b0, op_a} + {1'b0, op_b} + {8'h00, carry_in};
    assign sum8     = sum9[7:0];

    always_comb begin
        next_flags = 4'h0;
        next_flags[`CCA_FLAG_C] = sum9[8];
        next_flags[`CCA_FLAG_Z] = (sum8 == 8'h00);
        next_flags[`CCA_FLAG_S] = sum8[`CCA_SIGN_BIT];
        next_flags[`CCA_FLAG_V] = (op_a[`CCA_SIGN_BIT] == op_b[`CCA_SIGN_BIT])
                                & (sum8[`CCA_SIGN_BIT] != op_a[`CCA_SIGN_BIT]);
    end

    cca_cond_eval u_cond (
        .cond_select (op_cond),
        .flags       (flags_reg),
        .cond_true   (cond_true)
    );

    // destination: sum written back, source left alone
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dst_reg <= `CCA_RST_BYTE;
        end else if (is_add) begin
            dst_reg <= sum8;
        end else if (wr_dst) begin
            dst_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            src_reg <= `CCA_RST_BYTE;
        end else if (wr_src) begin
            src_reg <= pwdata[7:0];
        end
    end

    // flags: all four change together on an add, never on a jump
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags_reg <= `CCA_RST_FLAGS;
        end else if (is_add) begin
            flags_reg <= next_flags;
        end else if (wr_flags) begin
            flags_reg <= pwdata[3:0];
        end
    end

    // control: condition selector and software go request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cond_reg <= `CCA_RST_COND;
        end else if (wr_cond) begin
            cond_reg <= pwdata[`CCA_CTRL_COND_LSB +: 4];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pend_valid <= 1'b0;
            pend_op    <= CCA_OP_IDLE;
        end else if (wr_go
                     && (pwdata[`CCA_CTRL_GO_ADD] | pwdata[`CCA_CTRL_GO_ADC]
                         | pwdata[`CCA_CTRL_GO_JMP])) begin
            pend_valid <= 1'b1;
            if (pwdata[`CCA_CTRL_GO_ADD]) begin
                pend_op <= CCA_OP_ADD;
            end else if (pwdata[`CCA_CTRL_GO_ADC]) begin
                pend_op <= CCA_OP_ADC;
            end else begin
                pend_op <= CCA_OP_JMP;
            end
        end else if (pend_valid && !ex_ok) begin
            pend_valid <= 1'b0;
            pend_op    <= CCA_OP_IDLE;
        end
    end

    // jump target
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            target_reg <= `CCA_RST_PC;
        end else if (wr_target) begin
            if (pstrb[0]) begin
                target_reg[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                target_reg[15:8] <= pwdata[15:8];
            end
        end
    end

    // program counter: target when taken, next sequential otherwise
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pc_out <= `CCA_RST_PC;
        end else if (is_jmp) begin
            if (cond_true) begin
                pc_out <= target_reg;
            end else begin
                pc_out <= pc_out + `CCA_PC_STEP;
            end
        end else if (wr_pc) begin
            if (pstrb[0]) begin
                pc_out[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                pc_out[15:8] <= pwdata[15:8];
            end
        end
    end

    // jump decision
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            jump_valid <= 1'b0;
            jump_taken <= 1'b0;
        end else begin
            jump_valid <= is_jmp;
            if (is_jmp) begin
                jump_taken <= cond_true;
            end
        end
    end

    // add result to register file
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            res_valid <= 1'b0;
            res_data  <= `CCA_RST_BYTE;
        end else begin
            res_valid <= is_add;
            if (is_add) begin
                res_data <= sum8;
            end
        end
    end

    // flags to the core
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags_out <= `CCA_RST_FLAGS;
        end else if (is_add) begin
            flags_out <= next_flags;
        end else if (wr_flags) begin
            flags_out <= pwdata[3:0];
        end
    end

endmodule // cca_top

`default_nettype wire

// ==== bench/cca_ref_pkg.sv ====
// reference sum, flag and condition functions for the alu checks
`default_nettype none
package cca_ref_pkg;
    // returns {v, s, z, c, sum}
    function automatic logic [11:0] add_ref(input logic [7:0] d, input logic [7:0] s,
                                            input logic ci);
        logic [8:0] t;
        t = {1'b0, d} + {1'b0, s} + {8'h00, ci};
        return {(d[7] == s[7]) && (t[7] != d[7]), t[7], t[7:0] == 8'h00, t[8], t[7:0]};
    endfunction
    // flags: c bit0, z bit1, s bit2, v bit3; upper selector bit inverts the lower eight
    function automatic logic cond_ref(input logic [3:0] sel, input logic [3:0] f);
        logic       x;
        logic [7:0] b;
        x = f[2] ^ f[3];
        b = {f[0], f[1], f[2], f[3], f[0] | f[1], f[1] | x, x, 1'b0};
        return b[sel[2:0]] ^ sel[3];
    endfunction
endpackage
`default_nettype wire

// ==== bench/cca_top_sva.sv ====
// concurrent checks on the alu result and jump ports
`timescale 1ns/10ps
`default_nettype none
module cca_top_sva (
    // clock and reset
    input wire logic             clk_sys,
    input wire logic             rst,
    // decoder request
    input wire logic             ex_valid,
    input wire cca_pkg::cca_op_t ex_op,
    input wire logic [3:0]       ex_cond,
    input wire logic [7:0]       ex_dst,
    input wire logic [7:0]       ex_src,
    // results
    input wire logic             res_valid,
    input wire logic [7:0]       res_data,
    input wire logic [3:0]       flags_out,
    input wire logic             jump_valid,
    input wire logic             jump_taken,
    input wire logic [15:0]      pc_out
);
    import cca_pkg::*;
    import cca_ref_pkg::*;
    logic [11:0] exp_q;
    logic        is_add;
    logic        is_jmp;
    assign is_add = ex_valid && (ex_op == CCA_OP_ADD || ex_op == CCA_OP_ADC);
    assign is_jmp = ex_valid && ex_op == CCA_OP_JMP;
    always_ff @(posedge clk_sys) begin
        exp_q <= add_ref(ex_dst, ex_src, (ex_op == CCA_OP_ADC) && flags_out[0]);
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_add_sum: assert property (
        ex_valid && ex_op == CCA_OP_ADD |=> res_valid && res_data == exp_q[7:0])
        else $error("add sum wrong");
    a_adc_sum: assert property (
        ex_valid && ex_op == CCA_OP_ADC |=> res_valid && res_data == exp_q[7:0])
        else $error("adc sum wrong");
    a_carry_flag: assert property (is_add |=> flags_out[0] == exp_q[8])
        else $error("carry flag wrong");
    a_zero_sign: assert property (is_add |=> flags_out[2:1] == exp_q[10:9])
        else $error("zero or sign flag wrong");
    a_ovf_flag: assert property (is_add |=> flags_out[3] == exp_q[11])
        else $error("overflow flag wrong");
    a_never_always: assert property (
        is_jmp && ex_cond[2:0] == 3'h0 |=> jump_valid && jump_taken == $past(ex_cond[3]))
        else $error("fixed condition wrong");
    a_cond_decode: assert property (
        is_jmp |=> jump_valid && jump_taken == cond_ref($past(ex_cond), $past(flags_out)))
        else $error("condition decision wrong");
    a_untaken_step: assert property (
        is_jmp && !cond_ref(ex_cond, flags_out)
        |=> pc_out == $past(pc_out) + 16'h0002 && $stable(flags_out))
        else $error("untaken jump wrong");
    c_adc: cover property (ex_valid && ex_op == CCA_OP_ADC && flags_out[0]);
    c_taken: cover property (jump_valid && jump_taken);
    c_carry: cover property (res_valid && flags_out[0]);
endmodule // cca_top_sva
bind cca_top cca_top_sva cca_top_sva_inst (.clk_sys, .rst, .ex_valid, .ex_op, .ex_cond,
    .ex_dst, .ex_src, .res_valid, .res_data, .flags_out, .jump_valid, .jump_taken, .pc_out);
`default_nettype wire

// ==== bench/cca_decoder_model.sv ====
// instruction decoder model issuing one-cycle alu requests
`timescale 1ns/10ps
`default_nettype none
module cca_decoder_model (
    // clock
    input  wire logic       clk_sys,
    // request
    output var logic        ex_valid,
    output var cca_pkg::cca_op_t ex_op,
    output var logic [3:0]  ex_cond,
    output var logic [7:0]  ex_dst,
    output var logic [7:0]  ex_src
);
    import cca_pkg::*;
    initial begin
        ex_valid = 1'b0;
        ex_op = CCA_OP_IDLE;
        ex_cond = 4'h0;
        ex_dst = 8'h00;
        ex_src = 8'h00;
    end
    // request stands one cycle; operands scrambled afterwards
    task automatic issue(input cca_op_t op, input logic [3:0] c, input logic [7:0] d,
                         input logic [7:0] s);
        @(posedge clk_sys);
        ex_valid <= 1'b1;
        ex_op <= op;
        ex_cond <= c;
        ex_dst <= d;
        ex_src <= s;
        @(posedge clk_sys);
        ex_valid <= 1'b0;
        ex_dst <= ~d;
        ex_src <= ~s;
    endtask
endmodule // cca_decoder_model
`default_nettype wire

// ==== bench/cca_top_bench.sv ====
// self-checking bench for the condition/add alu
`timescale 1ns/10ps
`default_nettype none
`include "cca_defines.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module cca_top_bench;
    import cca_pkg::*;
    import cca_ref_pkg::*;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, err_q, t, cin;
    logic        ex_valid, res_valid, jump_valid, jump_taken;
    logic [7:0]  paddr, ex_dst, ex_src, res_data;
    logic [3:0]  pstrb, ex_cond, flags_out, fl;
    logic [31:0] pwdata, prdata, rd_q;
    logic [15:0] pc_out, pc;
    logic [11:0] r;
    cca_op_t     ex_op;
    int          failures, checked, cycles, i, f, c;
    cca_op_t     ops[6] = '{CCA_OP_ADD, CCA_OP_ADD, CCA_OP_ADC, CCA_OP_ADD, CCA_OP_ADD,
                            CCA_OP_ADC};
    logic [7:0]  da[6] = '{8'h12, 8'hFF, 8'h7F, 8'h80, 8'h10, 8'hFE};
    logic [7:0]  sa[6] = '{8'h03, 8'h01, 8'h00, 8'h80, 8'h03, 8'h01};
    cca_top cca_top_inst (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .ex_valid, .ex_op, .ex_cond, .ex_dst, .ex_src,
        .res_valid, .res_data, .flags_out, .jump_valid, .jump_taken, .pc_out);
    cca_decoder_model cca_decoder_model_inst (.clk_sys, .ex_valid, .ex_op, .ex_cond,
        .ex_dst, .ex_src);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task report_and_stop;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            failures++;
            report_and_stop;
        end
    end
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        fl = 4'h0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        for (i = 0; i < 6; i++) begin
            cin = (ops[i] == CCA_OP_ADC) & fl[0];
            r = add_ref(da[i], sa[i], cin);
            fl = r[11:8];
            cca_decoder_model_inst.issue(ops[i], 4'h0, da[i], sa[i]);
            @(negedge clk_sys);
            `CHK("res_valid", 1'b1, res_valid)
            `CHK("res_data", r[7:0], res_data)
            `CHK("flags_out", r[11:8], flags_out)
        end
        cca_decoder_model_inst.issue(cca_op_t'(3'b011), 4'h8, 8'h01, 8'h01);
        @(negedge clk_sys);
        `CHK("no result", 2'b00, {res_valid, jump_valid})
        apb(1'b1, `CCA_ADDR_TARGET, 32'h0000_1234);
        pc = 16'h0000;
        for (f = 0; f < 16; f++) begin
            apb(1'b1, `CCA_ADDR_FLAGS, 32'(f));
            for (c = 0; c < 16; c++) begin
                t = cond_ref(4'(c), 4'(f));
                cca_decoder_model_inst.issue(CCA_OP_JMP, 4'(c), 8'h00, 8'h00);
                @(negedge clk_sys);
                `CHK("jump_valid", 1'b1, jump_valid)
                `CHK("jump_taken", t, jump_taken)
                pc = t ? 16'h1234 : pc + 16'h0002;
                `CHK("pc_out", pc, pc_out)
                `CHK("flags kept", 4'(f), flags_out)
            end
        end
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped err", 1'b1, err_q)
        `CHK("unmapped data", 32'h0, rd_q)
        apb(1'b1, `CCA_ADDR_DST, 32'h0000_00C8);
        apb(1'b1, `CCA_ADDR_SRC, 32'h0000_0038);
        apb(1'b1, `CCA_ADDR_FLAGS, 32'h0000_000D);
        apb(1'b1, `CCA_ADDR_CTRL, 32'h0000_0100);
        repeat (2) @(posedge clk_sys);
        apb(1'b0, `CCA_ADDR_DST, 32'h0);
        `CHK("dst sum", 32'h0000_0000, rd_q)
        apb(1'b0, `CCA_ADDR_FLAGS, 32'h0);
        `CHK("flags c z", 32'h0000_0003, rd_q)
        report_and_stop;
    end
endmodule // cca_top_bench
`default_nettype wire
